/* include/mbsc_map.svh */
`ifndef MBSC_MAP_SVH
`define MBSC_MAP_SVH
// cpu-space addresses of the module base register halves
`define MBSC_MODULE_BASE_REGISTER_HI_ADDR 32'h0003FF00
`define MBSC_MODULE_BASE_REGISTER_LO_ADDR 32'h0003FF02
`define MBSC_FC_CPU 4'h7
`define MBSC_FC_SUP_DATA 4'h5
// offsets inside the 4-Kbyte block
`define MBSC_OFS_MCR 12'h000
`define MBSC_OFS_AVR_RSR 12'h006
// module base lower half fields
`define MBSC_LO_BASE_MSB 15
`define MBSC_LO_BASE_LSB 12
`define MBSC_LO_MASK_MSB 9
`define MBSC_LO_MASK_LSB 1
`define MBSC_LO_VALID 0
`define MBSC_LO_WMASK 16'hF3FF
// module configuration fields
`define MBSC_MCR_FRZ_TMR 14
`define MBSC_MCR_FRZ_BM 13
`define MBSC_MCR_AUTO_VECTOR_ACK 12
`define MBSC_MCR_SHOW_MSB 9
`define MBSC_MCR_SHOW_LSB 8
`define MBSC_MCR_SUPERVISOR_ONLY 7
`define MBSC_MCR_IARB_MSB 3
`define MBSC_MCR_IARB_LSB 0
`define MBSC_MCR_WMASK 16'h738F
`define MBSC_MCR_RESET 16'h008F
// reset values
`define MBSC_MODULE_BASE_REGISTER_RESET 16'h0000
`define MBSC_AVR_RESET 8'h00
`define MBSC_RSR_RESET 8'h00
// reset cause bit positions
`define MBSC_RSR_EXT 7
`define MBSC_RSR_POW 6
`define MBSC_RSR_SW 5
`define MBSC_RSR_DBF 4
`define MBSC_RSR_LOC 2
`define MBSC_RSR_SYS 1
`endif

/* include/mbsc_pkg.sv */
package mbsc_pkg;
	typedef struct packed {
		logic req;
		logic wr;
		logic [3:0] fc;
		logic [31:0] addr;
		logic [15:0] wdata;
		logic su_region;
	} mbsc_req_t;
	typedef struct packed {
		logic pin_reset_flag;
		logic powerup_reset_flag;
		logic sw;
		logic dbf;
		logic clock_loss_reset_flag;
		logic sys;
	} mbsc_cause_t;
	typedef enum {
		MBSC_ANS_NONE,
		MBSC_ANS_ACK,
		MBSC_ANS_BUS_ERROR_SIGNAL,
		MBSC_ANS_EXT,
		MBSC_ANS_PASS
	} mbsc_ans_t;
endpackage

/* rtl/mbsc_sys_config.sv */
// Behaviour
// - top 20 base register bits give the 4-Kbyte block start address.
// - access in a masked space skips the block and goes external.
// - nine mask bits: bit8 codes 1xxx, bit7..0 codes 0111..0000.
// - no block decode until the valid bit is one.
// - base register reached only by cpu-space accesses, never external.
// - timer-freeze bit plus freeze stops watchdog and periodic timer.
// - busmon-freeze bit plus freeze disables the bus monitor.
// - configuration bit enables automatic vector response during acknowledge.
// - show field 00 none+arb, 01 show no arb, 1x show+arb.
// - show cycle drives bus without address strobe, data strobe marks timing.
// - without show cycles internal accesses drive no data or strobes.
// - with arbitration disabled external bus requests are ignored.
// - supervisor-only set: user writes to shared registers discarded, bus error.
// - supervisor-only clear: shared registers open, function-code bit 2 ignored.
// - arbitration field resets to F; zero discards all module interrupts.
// - autovector level bit set asserts internal autovector on that acknowledge.
// - external autovectors only when arbitration field is non-zero.
// - one reset cause flag, updated at reset release, read-only.
// - flags for pin, power-up, watchdog and double-fault resets.
// - flag for clock-loss reset from the clock synthesizer.
// - instruction reset sets its flag, configuration registers keep values.
`timescale 1ns/1ps
`default_nettype none
`include "mbsc_map.svh"
module mbsc_sys_config (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_sys_rst,
	input wire mbsc_pkg::mbsc_cause_t i_rst_cause,
	// internal bus from the core
	input wire mbsc_pkg::mbsc_req_t i_bus,
	output logic o_ack,
	output logic o_bus_error_signal,
	output logic o_ext_cycle,
	output logic o_blk_sel,
	output logic [15:0] o_rdata,
	// show cycle strobes
	output logic o_show_as_n,
	output logic o_show_ds_n,
	output logic o_show_data_oe,
	// arbitration and freeze pins
	input wire logic i_ext_br,
	input wire logic i_freeze,
	output logic o_ext_br_seen,
	output logic o_timer_halt,
	output logic o_busmon_halt,
	// interrupt acknowledge
	input wire logic i_interrupt_ack_cycle,
	input wire logic [2:0] i_interrupt_ack_cycle_level,
	output logic o_autovec,
	output logic o_irq_discard,
	output logic [3:0] o_irq_arb_priority
);
	import mbsc_pkg::*;

	logic [15:0] module_base_register_hi_ff, nxt_module_base_register_hi;
	logic [15:0] module_base_register_lo_ff, nxt_module_base_register_lo;
	logic [15:0] mcr_ff, nxt_mcr;
	logic [7:0] avr_ff, nxt_avr;
	logic [7:0] rsr_ff, nxt_rsr;
	mbsc_cause_t cause_ff;
	logic in_rst_ff;
	logic [2:0] br_sync_ff, frz_sync_ff;
	logic ack_ff, bus_error_signal_ff, ext_ff, sel_ff, as_n_ff, ds_n_ff, doe_ff;
	logic [15:0] rdata_ff;
	logic br_seen_ff, thalt_ff, bhalt_ff, auto_vector_ack_ff, disc_ff;
	logic nxt_ack, nxt_bus_error_signal, nxt_ext, nxt_sel, nxt_ds_n, nxt_doe;
	logic [15:0] nxt_rdata;
	logic br_q, frz_q;
	logic [8:0] space_mask;
	logic [3:0] mask_idx;
	logic module_base_register_acc, blk_hit, user_acc, show_on, arb_on;
	logic [11:0] ofs;
	mbsc_ans_t ans;

	// base register field views
	assign space_mask = module_base_register_lo_ff[`MBSC_LO_MASK_MSB:`MBSC_LO_MASK_LSB];
	assign mask_idx = i_bus.fc[3] ? 4'h8 : {1'b0, i_bus.fc[2:0]};
	assign ofs = i_bus.addr[11:0];
	assign module_base_register_acc = (i_bus.fc == `MBSC_FC_CPU) && (i_bus.addr[31:2] == `MBSC_MODULE_BASE_REGISTER_HI_ADDR >> 2);
	assign blk_hit = module_base_register_lo_ff[`MBSC_LO_VALID]
		&& (i_bus.addr[31:12] == {module_base_register_hi_ff, module_base_register_lo_ff[`MBSC_LO_BASE_MSB:`MBSC_LO_BASE_LSB]})
		&& !space_mask[mask_idx];
	// function code only matters while supervisor-only is set, and then only code 5 counts as supervisor
	assign user_acc = mcr_ff[`MBSC_MCR_SUPERVISOR_ONLY] && (i_bus.fc != `MBSC_FC_SUP_DATA);
	assign show_on = mcr_ff[`MBSC_MCR_SHOW_MSB:`MBSC_MCR_SHOW_LSB] != 2'h0;
	assign arb_on = mcr_ff[`MBSC_MCR_SHOW_MSB:`MBSC_MCR_SHOW_LSB] != 2'h1;

	// request classification
	always_comb begin
		ans = MBSC_ANS_NONE;
		if (i_bus.req) begin
			if (module_base_register_acc) begin
				ans = MBSC_ANS_ACK;
			end else if (!blk_hit) begin
				ans = MBSC_ANS_EXT;
			end else if (ofs == `MBSC_OFS_MCR || ofs == `MBSC_OFS_AVR_RSR) begin
				ans = i_bus.fc[2] ? MBSC_ANS_ACK : MBSC_ANS_BUS_ERROR_SIGNAL;
			end else if (i_bus.su_region && user_acc && i_bus.wr) begin
				ans = MBSC_ANS_BUS_ERROR_SIGNAL;
			end else begin
				ans = MBSC_ANS_PASS;
			end
		end
	end

	// register writes and read data
	always_comb begin
		nxt_module_base_register_hi = module_base_register_hi_ff;
		nxt_module_base_register_lo = module_base_register_lo_ff;
		nxt_mcr = mcr_ff;
		nxt_avr = avr_ff;
		nxt_rdata = 16'h0000;
		if (ans == MBSC_ANS_ACK && module_base_register_acc) begin
			if (i_bus.wr && !i_bus.addr[1]) begin
				nxt_module_base_register_hi = i_bus.wdata;
			end else if (i_bus.wr) begin
				nxt_module_base_register_lo = i_bus.wdata & `MBSC_LO_WMASK;
			end
			nxt_rdata = i_bus.addr[1] ? module_base_register_lo_ff : module_base_register_hi_ff;
		end else if (ans == MBSC_ANS_ACK && ofs == `MBSC_OFS_MCR) begin
			if (i_bus.wr) begin
				nxt_mcr = i_bus.wdata & `MBSC_MCR_WMASK;
			end
			nxt_rdata = mcr_ff;
		end else if (ans == MBSC_ANS_ACK) begin
			if (i_bus.wr) begin
				nxt_avr = i_bus.wdata[15:8]; // reset cause half ignores writes
			end
			nxt_rdata = {avr_ff, rsr_ff};
		end
	end

	// one-hot cause, pin reset first at release; the instruction reset wins over release, no cause gives power-up
	always_comb begin
		nxt_rsr = rsr_ff;
		if (i_sys_rst) begin
			nxt_rsr = 8'h00;
			nxt_rsr[`MBSC_RSR_SYS] = 1'b1;
		end else if (in_rst_ff && !i_rst) begin
			nxt_rsr = 8'h00;
			if (cause_ff.pin_reset_flag) begin
				nxt_rsr[`MBSC_RSR_EXT] = 1'b1;
			end else if (cause_ff.powerup_reset_flag) begin
				nxt_rsr[`MBSC_RSR_POW] = 1'b1;
			end else if (cause_ff.sw) begin
				nxt_rsr[`MBSC_RSR_SW] = 1'b1;
			end else if (cause_ff.dbf) begin
				nxt_rsr[`MBSC_RSR_DBF] = 1'b1;
			end else if (cause_ff.clock_loss_reset_flag) begin
				nxt_rsr[`MBSC_RSR_LOC] = 1'b1;
			end else begin
				nxt_rsr[`MBSC_RSR_POW] = 1'b1;
			end
		end
	end

	// bus answer and show strobes
	always_comb begin
		nxt_ack = ans == MBSC_ANS_ACK;
		nxt_bus_error_signal = ans == MBSC_ANS_BUS_ERROR_SIGNAL;
		nxt_ext = ans == MBSC_ANS_EXT;
		nxt_sel = ans == MBSC_ANS_PASS;
		// internal cycles only appear outside when show cycles are on
		nxt_ds_n = !(show_on && (nxt_ack || nxt_sel || nxt_bus_error_signal) && !module_base_register_acc);
		nxt_doe = !nxt_ds_n;
	end

	// cause capture runs without reset so the pending cause survives reset
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			cause_ff <= i_rst_cause;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			module_base_register_hi_ff <= `MBSC_MODULE_BASE_REGISTER_RESET;
			module_base_register_lo_ff <= `MBSC_MODULE_BASE_REGISTER_RESET;
			mcr_ff <= `MBSC_MCR_RESET;
			avr_ff <= `MBSC_AVR_RESET;
			rsr_ff <= `MBSC_RSR_RESET;
			in_rst_ff <= 1'b1;
			br_sync_ff <= 3'h0;
			frz_sync_ff <= 3'h0;
			ack_ff <= 1'b0;
			bus_error_signal_ff <= 1'b0;
			ext_ff <= 1'b0;
			sel_ff <= 1'b0;
			rdata_ff <= 16'h0000;
			as_n_ff <= 1'b1;
			ds_n_ff <= 1'b1;
			doe_ff <= 1'b0;
			br_seen_ff <= 1'b0;
			thalt_ff <= 1'b0;
			bhalt_ff <= 1'b0;
			auto_vector_ack_ff <= 1'b0;
			disc_ff <= 1'b0;
		end else begin
			module_base_register_hi_ff <= nxt_module_base_register_hi;
			module_base_register_lo_ff <= nxt_module_base_register_lo;
			mcr_ff <= nxt_mcr; // instruction reset leaves configuration alone
			avr_ff <= nxt_avr;
			rsr_ff <= nxt_rsr;
			in_rst_ff <= 1'b0;
			br_sync_ff <= {br_sync_ff[1:0], i_ext_br};
			frz_sync_ff <= {frz_sync_ff[1:0], i_freeze};
			ack_ff <= nxt_ack;
			bus_error_signal_ff <= nxt_bus_error_signal;
			ext_ff <= nxt_ext;
			sel_ff <= nxt_sel;
			rdata_ff <= nxt_rdata;
			as_n_ff <= 1'b1;
			ds_n_ff <= nxt_ds_n;
			doe_ff <= nxt_doe;
			br_seen_ff <= br_q && arb_on;
			thalt_ff <= frz_q && mcr_ff[`MBSC_MCR_FRZ_TMR];
			bhalt_ff <= frz_q && mcr_ff[`MBSC_MCR_FRZ_BM];
			auto_vector_ack_ff <= i_interrupt_ack_cycle && mcr_ff[`MBSC_MCR_AUTO_VECTOR_ACK] && avr_ff[i_interrupt_ack_cycle_level]
				&& (mcr_ff[`MBSC_MCR_IARB_MSB:`MBSC_MCR_IARB_LSB] != 4'h0);
			disc_ff <= i_interrupt_ack_cycle && (mcr_ff[`MBSC_MCR_IARB_MSB:`MBSC_MCR_IARB_LSB] == 4'h0);
		end
	end

	// pin inputs change only when the last two stages agree
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			br_q <= 1'b0;
			frz_q <= 1'b0;
		end else begin
			br_q <= (br_sync_ff[2] == br_sync_ff[1]) ? br_sync_ff[2] : br_q;
			frz_q <= (frz_sync_ff[2] == frz_sync_ff[1]) ? frz_sync_ff[2] : frz_q;
		end
	end

	assign o_ack = ack_ff;
	assign o_bus_error_signal = bus_error_signal_ff;
	assign o_ext_cycle = ext_ff;
	assign o_blk_sel = sel_ff;
	assign o_rdata = rdata_ff;
	assign o_show_as_n = as_n_ff;
	assign o_show_ds_n = ds_n_ff;
	assign o_show_data_oe = doe_ff;
	assign o_ext_br_seen = br_seen_ff;
	assign o_timer_halt = thalt_ff;
	assign o_busmon_halt = bhalt_ff;
	assign o_autovec = auto_vector_ack_ff;
	assign o_irq_discard = disc_ff;
	assign o_irq_arb_priority = mcr_ff[`MBSC_MCR_IARB_MSB:`MBSC_MCR_IARB_LSB];
endmodule // mbsc_sys_config
`default_nettype wire

/* tb/mbsc_sys_config_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module mbsc_sys_config_assertions (
	// watched ports
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire mbsc_pkg::mbsc_req_t i_bus,
	input wire logic o_ack,
	input wire logic o_bus_error_signal,
	input wire logic o_ext_cycle,
	input wire logic o_blk_sel,
	input wire logic o_show_as_n,
	input wire logic o_show_ds_n,
	input wire logic o_show_data_oe,
	input wire logic i_ext_br,
	input wire logic i_freeze,
	input wire logic o_ext_br_seen,
	input wire logic o_timer_halt,
	input wire logic o_busmon_halt,
	input wire logic i_interrupt_ack_cycle,
	input wire logic o_autovec,
	input wire logic o_irq_discard,
	input wire logic [3:0] o_irq_arb_priority
);
	import mbsc_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	logic [3:0] ans;
	assign ans = {o_ack, o_bus_error_signal, o_ext_cycle, o_blk_sel};
	sequence s_cpu;
		i_bus.req && i_bus.fc == 4'h7 && i_bus.addr[31:2] == 30'h0000FFC0;
	endsequence
	// pins pass three stages, a filter and an output flop: judge one cycle after five quiet samples
	sequence s_no_br;
		!i_ext_br [*5];
	endsequence
	sequence s_no_frz;
		!i_freeze [*5];
	endsequence
	property p_one; i_bus.req |=> $onehot(ans); endproperty
	property p_idle; !i_bus.req |=> ans == 4'h0; endproperty
	property p_cpu; s_cpu |=> o_ack; endproperty
	property p_as; o_show_as_n; endproperty
	property p_oe; o_show_data_oe == !o_show_ds_n; endproperty
	property p_nods; !i_bus.req |=> o_show_ds_n; endproperty
	property p_disc; i_interrupt_ack_cycle && o_irq_arb_priority == 4'h0 |=> o_irq_discard; endproperty
	property p_noav; i_interrupt_ack_cycle && o_irq_arb_priority == 4'h0 |=> !o_autovec; endproperty
	property p_br; s_no_br |=> !o_ext_br_seen; endproperty
	property p_thalt; s_no_frz |=> !o_timer_halt; endproperty
	property p_bhalt; s_no_frz |=> !o_busmon_halt; endproperty
	a_one: assert property (p_one) else $error("not one answer");
	a_idle: assert property (p_idle) else $error("answer without request");
	a_cpu: assert property (p_cpu) else $error("base access not acked");
	a_as: assert property (p_as) else $error("address strobe driven");
	a_oe: assert property (p_oe) else $error("data enable off strobe");
	a_nods: assert property (p_nods) else $error("strobe without access");
	a_disc: assert property (p_disc) else $error("interrupt not discarded");
	a_noav: assert property (p_noav) else $error("autovector with zero field");
	a_br: assert property (p_br) else $error("request seen without pin");
	a_thalt: assert property (p_thalt) else $error("timer halt without freeze");
	a_bhalt: assert property (p_bhalt) else $error("busmon halt without freeze");
endmodule // mbsc_sys_config_assertions
bind mbsc_sys_config mbsc_sys_config_assertions u_chk (.i_core_clk, .i_rst, .i_bus, .o_ack, .o_bus_error_signal,
	.o_ext_cycle, .o_blk_sel, .o_show_as_n, .o_show_ds_n, .o_show_data_oe, .i_ext_br, .i_freeze,
	.o_ext_br_seen, .o_timer_halt, .o_busmon_halt, .i_interrupt_ack_cycle, .o_autovec, .o_irq_discard, .o_irq_arb_priority);
`default_nettype wire

/* tb/mbsc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mbsc_core_model (
	// bus towards the block
	input wire logic i_core_clk,
	input wire logic [3:0] i_ans,
	input wire logic [15:0] i_rdata,
	output var mbsc_pkg::mbsc_req_t o_bus
);
	import mbsc_pkg::*;
	initial o_bus = '0;
	// one-cycle request; afterwards lines are inverted so stale values never look valid
	task automatic xfer(input logic w, input logic [3:0] f, input logic [31:0] a, input logic [15:0] d,
		input logic s, output logic [3:0] ans, output logic [15:0] rd);
		@(negedge i_core_clk);
		o_bus = '{1'b1, w, f, a, d, s};
		@(negedge i_core_clk);
		ans = i_ans;
		rd = i_rdata;
		o_bus = '{1'b0, ~w, ~f, ~a, ~d, ~s};
	endtask
endmodule // mbsc_core_model
`default_nettype wire

/* tb/mbsc_sys_config_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module mbsc_sys_config_bench;
	import mbsc_pkg::*;
	localparam logic [31:0] blk = 32'hFFFFF000;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_sys_rst = 1'b0;
	mbsc_cause_t i_rst_cause = '0;
	mbsc_req_t i_bus;
	logic i_ext_br = 1'b0;
	logic i_freeze = 1'b0;
	logic i_interrupt_ack_cycle = 1'b0;
	logic [2:0] i_interrupt_ack_cycle_level = 3'h0;
	logic o_ack, o_bus_error_signal, o_ext_cycle, o_blk_sel, o_show_as_n, o_show_ds_n, o_show_data_oe;
	logic o_ext_br_seen, o_timer_halt, o_busmon_halt, o_autovec, o_irq_discard;
	logic [3:0] o_irq_arb_priority;
	logic [15:0] o_rdata;
	logic [15:0] rd;
	logic [3:0] ans;
	int n_mismatch = 0;
	int n_checks = 0;
	int n_ds = 0;
	int k;
	always #10 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) if (!o_show_ds_n) n_ds++;
	mbsc_sys_config DUT (.i_core_clk, .i_rst, .i_sys_rst, .i_rst_cause, .i_bus, .o_ack, .o_bus_error_signal,
		.o_ext_cycle, .o_blk_sel, .o_rdata, .o_show_as_n, .o_show_ds_n, .o_show_data_oe, .i_ext_br,
		.i_freeze, .o_ext_br_seen, .o_timer_halt, .o_busmon_halt, .i_interrupt_ack_cycle, .i_interrupt_ack_cycle_level, .o_autovec,
		.o_irq_discard, .o_irq_arb_priority);
	mbsc_core_model core (.i_core_clk, .i_ans({o_ack, o_bus_error_signal, o_ext_cycle, o_blk_sel}), .i_rdata(o_rdata),
		.o_bus(i_bus));
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// answer code ea is {ack, bus_error_signal, ext, blk}
	task automatic acc(input logic w, input logic [3:0] f, input logic [31:0] a, input logic [15:0] d,
		input logic s, input logic [3:0] ea);
		core.xfer(w, f, a, d, s, ans, rd);
		chk(16'(ans), 16'(ea));
	endtask
	task automatic base(input logic [15:0] lo);
		acc(1'b1, 4'h7, 32'h3FF00, 16'hFFFF, 1'b0, 4'h8);
		acc(1'b1, 4'h7, 32'h3FF02, lo, 1'b0, 4'h8);
	endtask
	task automatic cfg(input logic [15:0] v);
		acc(1'b1, 4'h5, blk, v, 1'b0, 4'h8);
	endtask
	task automatic rstc(input mbsc_cause_t c);
		@(negedge i_core_clk);
		i_rst = 1'b1;
		i_rst_cause = c;
		repeat (4) @(negedge i_core_clk);
		i_rst = 1'b0;
	endtask
	task automatic shows(input int e);
		@(negedge i_core_clk);
		k = n_ds;
		acc(1'b0, 4'h5, blk, 16'h0, 1'b0, 4'h8);
		acc(1'b0, 4'h5, blk, 16'h0, 1'b0, 4'h8);
		@(negedge i_core_clk);
		chk(16'(n_ds - k), 16'(e));
	endtask
	task automatic interrupt_ack_cycle(input logic [2:0] l, input logic [1:0] e);
		@(negedge i_core_clk);
		i_interrupt_ack_cycle = 1'b1;
		i_interrupt_ack_cycle_level = l;
		@(negedge i_core_clk);
		i_interrupt_ack_cycle = 1'b0;
		chk(16'({o_autovec, o_irq_discard}), 16'(e));
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		rstc(6'h00);
		acc(1'b0, 4'h7, 32'h3FF02, 16'h0, 1'b0, 4'h8);
		chk(rd, 16'h0000);
		acc(1'b0, 4'h5, blk, 16'h0, 1'b0, 4'h2);
		chk(16'(o_irq_arb_priority), 16'h000F);
		base(16'hFD01);
		acc(1'b0, 4'h7, 32'h3FF02, 16'h0, 1'b0, 4'h8);
		chk(rd, 16'hF101);
		acc(1'b0, 4'h5, blk, 16'h0, 1'b0, 4'h8);
		chk(rd, 16'h008F);
		for (int i = 0; i < 9; i++) begin
			base(16'hF001 | (16'h2 << i));
			acc(1'b0, (i == 8) ? 4'h8 : 4'(i), blk + 32'h10, 16'h0, 1'b0, 4'h2);
			acc(1'b0, 4'h5, blk + 32'h10, 16'h0, 1'b0, (i == 5) ? 4'h2 : 4'h1);
		end
		base(16'hF001);
		$display("test base done");
		cfg(16'hFFFF);
		acc(1'b0, 4'h5, blk, 16'h0, 1'b0, 4'h8);
		chk(rd, 16'h738F);
		shows(2);
		cfg(16'h700F);
		shows(0);
		i_freeze = 1'b1;
		i_ext_br = 1'b1;
		repeat (5) @(negedge i_core_clk);
		chk(16'({o_timer_halt, o_busmon_halt, o_ext_br_seen}), 16'h7);
		cfg(16'h0107);
		repeat (5) @(negedge i_core_clk);
		chk(16'({o_timer_halt, o_busmon_halt, o_ext_br_seen}), 16'h0);
		i_freeze = 1'b0;
		i_ext_br = 1'b0; // no outside master while show cycles run without arbitration
		shows(2);
		$display("test config done");
		cfg(16'h108F);
		acc(1'b1, 4'h1, blk + 32'h10, 16'h0, 1'b1, 4'h4);
		acc(1'b1, 4'h5, blk + 32'h10, 16'h0, 1'b1, 4'h1);
		acc(1'b0, 4'h1, blk, 16'h0, 1'b0, 4'h4);
		cfg(16'h100F);
		acc(1'b1, 4'h1, blk + 32'h10, 16'h0, 1'b1, 4'h1);
		acc(1'b1, 4'h5, blk + 32'h6, 16'h0800, 1'b0, 4'h8);
		interrupt_ack_cycle(3'h3, 2'b10);
		interrupt_ack_cycle(3'h2, 2'b00);
		cfg(16'h1000);
		interrupt_ack_cycle(3'h3, 2'b01);
		cfg(16'h000F);
		interrupt_ack_cycle(3'h3, 2'b00);
		$display("test access done");
		for (int j = 0; j < 5; j++) begin
			rstc(6'h20 >> j);
			base(16'hF001);
			acc(1'b0, 4'h5, blk + 32'h6, 16'h0, 1'b0, 4'h8);
			chk(rd, {8'h00, (j == 4) ? 8'h04 : (8'h80 >> j)});
		end
		acc(1'b1, 4'h5, blk + 32'h6, 16'h00FF, 1'b0, 4'h8);
		acc(1'b0, 4'h5, blk + 32'h6, 16'h0, 1'b0, 4'h8);
		chk(rd, 16'h0004);
		cfg(16'h0007);
		@(negedge i_core_clk);
		i_sys_rst = 1'b1;
		@(negedge i_core_clk);
		i_sys_rst = 1'b0;
		repeat (2) @(negedge i_core_clk);
		acc(1'b0, 4'h5, blk + 32'h6, 16'h0, 1'b0, 4'h8);
		chk(rd, 16'h0002);
		acc(1'b0, 4'h5, blk, 16'h0, 1'b0, 4'h8);
		chk(rd, 16'h0007);
		$display("test reset cause done");
		results();
	end
endmodule // mbsc_sys_config_bench
`default_nettype wire
